// >>> src/dlb_ctrl.sv
`timescale 1ns/10ps
`include "dlb_consts.svh"
module dlb_ctrl
   import dlb_pkg::*;
#(
   parameter int TICK_CYC     = `DLB_TICK_NS / `DLB_CLK_PERIOD_NS,
   parameter int TICKS_PER_S  = `DLB_TICKS_PER_S,
   parameter int STARTUP_TCK  = `DLB_STARTUP_S * TICKS_PER_S,
   parameter int DATA_TCK     = `DLB_DATA_S * TICKS_PER_S,
   parameter int GEN_EN_TCK   = `DLB_GEN_EN_S * TICKS_PER_S,
   parameter int RDL_END_TCK  = `DLB_RDL_END_S * TICKS_PER_S,
   parameter int GEN_TO_TCK   = `DLB_GEN_TIMEOUT_S * TICKS_PER_S,
   parameter int FLASH_TCK    = `DLB_FLASH_MS,
   parameter int BLINK_TCK    = `DLB_BLINK_MS,
   parameter int INJECT_GAP   = `DLB_INJECT_GAP,
   parameter int FIFO_DEPTH   = `DLB_FIFO_DEPTH
) (
   input  wire logic CLK_I,
   input  wire logic SYS_RST_I,
   input  wire logic RX_PKT_I,
   input  wire logic RX_PKT_FRAMED_I,
   input  wire logic CRC_ERR_I,
   input  wire logic TEST_SW_I,
   input  wire logic PAT_ERR_SW_I,
   input  wire logic REMOTE_LOOP_REQ_I,
   input  wire logic FR_TX_VALID_I,
   input  wire logic FR_TX_BIT_I,
   output logic      FR_TX_READY_O,
   output logic      LINE_TX_VALID_O,
   output logic      LINE_TX_BIT_O,
   input  wire logic LINE_TX_READY_I,
   input  wire logic LINE_RX_VALID_I,
   input  wire logic LINE_RX_BIT_I,
   output logic      FR_RX_VALID_O,
   output logic      FR_RX_BIT_O,
   output logic      LINK_IND_O,
   output logic      RESTART_O,
   output logic      REMOTE_DIGITAL_LOOP_O,
   output logic      ERROR_INDICATOR_O,
   output logic      TEST_MODE_INDICATOR_O
);
   localparam int TW = `DLB_TW;

   logic [31:0]   div_r;
   logic          tick;
   logic          link_r;
   dlb_mode_t     mode_r;
   logic [TW-1:0] run_cnt_r;
   logic [TW-1:0] thr;
   logic [TW-1:0] thr_q_r;
   logic          restart;
   logic          restart_r;
   dlb_gen_t      gen_r;
   logic [TW-1:0] gen_cnt_r;
   logic [8:0]    prbs_r;
   logic [8:0]    chk_r;
   logic [3:0]    sync_r;
   logic [15:0]   inj_cnt_r;
   logic          inject;
   logic          gen_bit;
   logic          bit_err;
   logic [TW-1:0] flash_r;
   logic [TW-1:0] blink_cnt_r;
   logic          blink_r;
   logic          err_ind_r;
   logic          tm_ind_r;
   logic          loop_cmd_r;
   logic          fr_rx_v_r;
   logic          fr_rx_b_r;
   dlb_src_t      src;
   logic          f_in_valid;
   logic          f_in_data;
   logic          f_in_ready;
   logic          gen_take;

   // Seconds-scale timers run on a millisecond tick
   always_ff @(posedge CLK_I or posedge SYS_RST_I) begin
      if (SYS_RST_I) begin
         div_r <= '0;
      end else if (div_r == 32'(TICK_CYC - 1)) begin
         div_r <= '0;
      end else begin
         div_r <= div_r + 32'h1;
      end
   end
   assign tick = (div_r == 32'(TICK_CYC - 1));
   always_ff @(posedge CLK_I or posedge SYS_RST_I) begin
      if (SYS_RST_I) begin
         link_r <= 1'b0;
      end else if (restart) begin
         link_r <= 1'b0;
      end else if (RX_PKT_I) begin
         link_r <= RX_PKT_FRAMED_I;
      end
   end

   always_ff @(posedge CLK_I or posedge SYS_RST_I) begin
      if (SYS_RST_I) begin
         mode_r <= LM_STARTUP;
      end else if (restart) begin
         mode_r <= LM_STARTUP;
      end else if (RX_PKT_I && RX_PKT_FRAMED_I) begin
         mode_r <= LM_DATA;
      end
   end

   // Loop and generator both look like a dead line to the framer
   always_comb begin
      if (REMOTE_LOOP_REQ_I) begin
         thr = TW'(RDL_END_TCK);
      end else if (gen_r == GS_RUN) begin
         thr = TW'(GEN_EN_TCK);
      end else if (mode_r == LM_STARTUP) begin
         thr = TW'(STARTUP_TCK);
      end else begin
         thr = TW'(DATA_TCK);
      end
   end

   assign restart = tick && !link_r && (run_cnt_r == thr - TW'(1));
   // New threshold restarts count, so a test end cannot trip it
   always_ff @(posedge CLK_I or posedge SYS_RST_I) begin
      if (SYS_RST_I) begin
         run_cnt_r <= '0;
      end else if (link_r || restart || thr != thr_q_r) begin
         run_cnt_r <= '0;
      end else if (tick) begin
         run_cnt_r <= run_cnt_r + TW'(1);
      end
   end
   always_ff @(posedge CLK_I or posedge SYS_RST_I) begin
      if (SYS_RST_I) begin
         restart_r <= 1'b0;
         thr_q_r   <= TW'(STARTUP_TCK);
      end else begin
         restart_r <= restart;
         thr_q_r   <= thr;
      end
   end
   // Generator only starts from idle, and not while a remote loop is requested
   always_ff @(posedge CLK_I or posedge SYS_RST_I) begin
      if (SYS_RST_I) begin
         gen_r     <= GS_IDLE;
         gen_cnt_r <= '0;
      end else begin
         case (gen_r)
            GS_IDLE: begin
               gen_cnt_r <= '0;
               if (TEST_SW_I && !REMOTE_LOOP_REQ_I) begin
                  gen_r <= GS_RUN;
               end
            end
            GS_RUN: begin
               if (!TEST_SW_I) begin
                  gen_r <= GS_IDLE;
               end else if (tick) begin
                  if (gen_cnt_r == TW'(GEN_TO_TCK - 1)) begin
                     gen_r <= GS_DONE;
                  end else begin
                     gen_cnt_r <= gen_cnt_r + TW'(1);
                  end
               end
            end
            GS_DONE: begin
               if (!TEST_SW_I) begin
                  gen_r <= GS_IDLE;
               end
            end
            default: begin
               gen_r <= GS_IDLE;
            end
         endcase
      end
   end

   always_comb begin
      if (gen_r == GS_RUN) begin
         src = SRC_GEN;
      end else if (REMOTE_LOOP_REQ_I) begin
         src = SRC_LOOP;
      end else begin
         src = SRC_FRAMER;
      end
   end

   assign inject  = PAT_ERR_SW_I && (inj_cnt_r == 16'(INJECT_GAP - 1));
   assign gen_bit = prbs_r[`DLB_PRBS_TAP_A] ^ inject;

   always_comb begin
      case (src)
         SRC_GEN: begin
            f_in_valid = 1'b1;
            f_in_data  = gen_bit;
         end
         SRC_LOOP: begin
            f_in_valid = LINE_RX_VALID_I;
            f_in_data  = LINE_RX_BIT_I;
         end
         default: begin
            f_in_valid = FR_TX_VALID_I;
            f_in_data  = FR_TX_BIT_I;
         end
      endcase
   end

   assign FR_TX_READY_O = (src == SRC_FRAMER) && f_in_ready;
   assign gen_take      = (src == SRC_GEN) && f_in_ready;
   dlb_fifo #(
      .W (1),
      .D (FIFO_DEPTH)
   ) u_fifo (
      .clk_i       (CLK_I),
      .rst_i       (SYS_RST_I),
      .in_valid_i  (f_in_valid),
      .in_data_i   (f_in_data),
      .in_ready_o  (f_in_ready),
      .out_valid_o (LINE_TX_VALID_O),
      .out_data_o  (LINE_TX_BIT_O),
      .out_ready_i (LINE_TX_READY_I)
   );

   // Nine-stage shift register, taps give a 511-bit period
   always_ff @(posedge CLK_I or posedge SYS_RST_I) begin
      if (SYS_RST_I) begin
         prbs_r    <= `DLB_PRBS_SEED;
         inj_cnt_r <= '0;
      end else if (gen_take) begin
         prbs_r <= {prbs_r[7:0],
                    prbs_r[`DLB_PRBS_TAP_A] ^ prbs_r[`DLB_PRBS_TAP_B]};
         if (inj_cnt_r == 16'(INJECT_GAP - 1)) begin
            inj_cnt_r <= '0;
         end else begin
            inj_cnt_r <= inj_cnt_r + 16'h1;
         end
      end
   end

   // Self-synchronising checker; needs nine bits before judging
   always_ff @(posedge CLK_I or posedge SYS_RST_I) begin
      if (SYS_RST_I) begin
         chk_r  <= '0;
         sync_r <= '0;
      end else if (gen_r != GS_RUN) begin
         sync_r <= '0;
      end else if (LINE_RX_VALID_I) begin
         chk_r <= {chk_r[7:0], LINE_RX_BIT_I};
         if (sync_r != 4'h9) begin
            sync_r <= sync_r + 4'h1;
         end
      end
   end

   assign bit_err = (gen_r == GS_RUN) && LINE_RX_VALID_I
                    && (sync_r == 4'h9)
                    && (LINE_RX_BIT_I !=
                        (chk_r[`DLB_PRBS_TAP_A] ^ chk_r[`DLB_PRBS_TAP_B]));

   // Stretch so a single error is visible on the lamp
   always_ff @(posedge CLK_I or posedge SYS_RST_I) begin
      if (SYS_RST_I) begin
         flash_r <= '0;
      end else if (bit_err) begin
         flash_r <= TW'(FLASH_TCK);
      end else if (CRC_ERR_I && link_r && gen_r == GS_IDLE) begin
         flash_r <= TW'(FLASH_TCK);
      end else if (tick && flash_r != '0) begin
         flash_r <= flash_r - TW'(1);
      end
   end

   always_ff @(posedge CLK_I or posedge SYS_RST_I) begin
      if (SYS_RST_I) begin
         blink_cnt_r <= '0;
         blink_r     <= 1'b0;
      end else if (gen_r != GS_DONE) begin
         blink_cnt_r <= '0;
         blink_r     <= 1'b1;
      end else if (tick) begin
         if (blink_cnt_r == TW'(BLINK_TCK - 1)) begin
            blink_cnt_r <= '0;
            blink_r     <= !blink_r;
         end else begin
            blink_cnt_r <= blink_cnt_r + TW'(1);
         end
      end
   end

   always_ff @(posedge CLK_I or posedge SYS_RST_I) begin
      if (SYS_RST_I) begin
         err_ind_r  <= 1'b0;
         tm_ind_r   <= 1'b0;
         loop_cmd_r <= 1'b0;
         fr_rx_v_r  <= 1'b0;
         fr_rx_b_r  <= 1'b0;
      end else begin
         err_ind_r  <= (flash_r != '0)
                       || (gen_r == GS_DONE && blink_r);
         tm_ind_r   <= TEST_SW_I || REMOTE_LOOP_REQ_I;
         loop_cmd_r <= (gen_r == GS_RUN);
         fr_rx_v_r  <= LINE_RX_VALID_I;
         fr_rx_b_r  <= LINE_RX_BIT_I;
      end
   end

   assign LINK_IND_O            = link_r;
   assign RESTART_O             = restart_r;
   assign ERROR_INDICATOR_O     = err_ind_r;
   assign TEST_MODE_INDICATOR_O = tm_ind_r;
   assign REMOTE_DIGITAL_LOOP_O = loop_cmd_r;
   assign FR_RX_VALID_O         = fr_rx_v_r;
   assign FR_RX_BIT_O           = fr_rx_b_r;

   a_link_framed: assert property (@(posedge CLK_I) disable iff (SYS_RST_I)
      RX_PKT_I && !restart |=> LINK_IND_O == $past(RX_PKT_FRAMED_I))
      else $error("link indicator wrong after packet");
   a_restart_at: assert property (@(posedge CLK_I) disable iff (SYS_RST_I)
      RESTART_O |-> $past(run_cnt_r) == $past(thr) - TW'(1)
                    && !$past(link_r))
      else $error("restart at wrong count");
   a_restart_mode: assert property (@(posedge CLK_I) disable iff (SYS_RST_I)
      RESTART_O |-> mode_r == LM_STARTUP && !LINK_IND_O)
      else $error("restart did not return to startup");
   a_thr_data: assert property (@(posedge CLK_I) disable iff (SYS_RST_I)
      mode_r == LM_DATA && gen_r != GS_RUN && !REMOTE_LOOP_REQ_I
      |-> thr == TW'(DATA_TCK))
      else $error("data mode threshold wrong");
   a_thr_remote: assert property (@(posedge CLK_I) disable iff (SYS_RST_I)
      REMOTE_LOOP_REQ_I |-> thr == TW'(RDL_END_TCK))
      else $error("remote end threshold wrong");
   a_thr_gen: assert property (@(posedge CLK_I) disable iff (SYS_RST_I)
      gen_r == GS_RUN |-> thr == TW'(GEN_EN_TCK) && src == SRC_GEN)
      else $error("generator threshold or source wrong");
   a_gen_timeout: assert property (@(posedge CLK_I) disable iff (SYS_RST_I)
      gen_r == GS_RUN && TEST_SW_I && tick
      && gen_cnt_r == TW'(GEN_TO_TCK - 1)
      |=> gen_r == GS_DONE ##1 src != SRC_GEN)
      else $error("generator did not time out");
   a_gen_bound: assert property (@(posedge CLK_I) disable iff (SYS_RST_I)
      gen_cnt_r < TW'(GEN_TO_TCK) && GEN_TO_TCK < RDL_END_TCK)
      else $error("generator outlives peer timer");
   a_done_hold: assert property (@(posedge CLK_I) disable iff (SYS_RST_I)
      gen_r == GS_DONE && TEST_SW_I |=> gen_r == GS_DONE)
      else $error("timeout state left with switch down");
   a_done_clear: assert property (@(posedge CLK_I) disable iff (SYS_RST_I)
      gen_r == GS_DONE && !TEST_SW_I
      |=> gen_r == GS_IDLE ##1 (!ERROR_INDICATOR_O || $past(flash_r) != '0))
      else $error("blink not stopped by switch");
   a_loop_data: assert property (@(posedge CLK_I) disable iff (SYS_RST_I)
      src == SRC_LOOP |-> f_in_valid == LINE_RX_VALID_I
                          && f_in_data == LINE_RX_BIT_I)
      else $error("loopback path not closed");
   a_err_flash: assert property (@(posedge CLK_I) disable iff (SYS_RST_I)
      bit_err |=> ##1 ERROR_INDICATOR_O)
      else $error("bit error not flashed");
   a_err_inject: assert property (@(posedge CLK_I) disable iff (SYS_RST_I)
      gen_take && inject |-> f_in_data != prbs_r[`DLB_PRBS_TAP_A])
      else $error("error not injected");
   a_tm_ind: assert property (@(posedge CLK_I) disable iff (SYS_RST_I)
      TEST_SW_I || REMOTE_LOOP_REQ_I |=> TEST_MODE_INDICATOR_O)
      else $error("test mode indicator off");

   c_restart: cover property (@(posedge CLK_I) disable iff (SYS_RST_I)
      RESTART_O);
   c_timeout: cover property (@(posedge CLK_I) disable iff (SYS_RST_I)
      gen_r == GS_RUN ##1 gen_r == GS_DONE);
   c_bit_err: cover property (@(posedge CLK_I) disable iff (SYS_RST_I)
      bit_err);
   c_loop: cover property (@(posedge CLK_I) disable iff (SYS_RST_I)
      src == SRC_LOOP && LINE_RX_VALID_I && f_in_ready);
endmodule

// >>> src/dlb_consts.svh
`ifndef DLB_CONSTS_SVH
`define DLB_CONSTS_SVH
// Function
// - Link indicator follows framed packet arrival
// - Restart timer expiry restarts and reconnects
// - Restart threshold 50 s startup, 4 s data
// - Remote loop end uses 60 s threshold
// - Local generator running uses 60 s threshold
// - Generator stops after 45 s, data restored
// - Timeout blinks error indicator until switch up
// - Pattern inserted after framer, sent unframed
// - Generator timeout precedes peer restart expiry
// - Remote end loops received pattern back
// - Originator checks pattern, flashes on errors
// - Switch down starts loop and clean pattern
// - Pattern switch up injects deliberate errors
// - Flash per CRC error (link up, generator idle) or bit error
// - Test mode indicator lit during tests
`define DLB_CLK_PERIOD_NS 5
`define DLB_TICK_NS       1000000
`define DLB_TICKS_PER_S   1000
`define DLB_STARTUP_S     50
`define DLB_DATA_S        4
`define DLB_GEN_EN_S      60
`define DLB_RDL_END_S     60
`define DLB_GEN_TIMEOUT_S 45
`define DLB_FLASH_MS      100
`define DLB_BLINK_MS      250
`define DLB_INJECT_GAP    256
`define DLB_FIFO_DEPTH    4
`define DLB_PRBS_SEED     9'h1ff
`define DLB_PRBS_TAP_A    8
`define DLB_PRBS_TAP_B    4
`define DLB_TW            20
`endif

// >>> src/dlb_pkg.sv
package dlb_pkg;
   typedef enum logic [0:0] {
      LM_STARTUP = 1'b0,
      LM_DATA    = 1'b1
   } dlb_mode_t;
   typedef enum logic [1:0] {
      GS_IDLE = 2'b00,
      GS_RUN  = 2'b01,
      GS_DONE = 2'b10
   } dlb_gen_t;
   typedef enum logic [1:0] {
      SRC_FRAMER = 2'b00,
      SRC_GEN    = 2'b01,
      SRC_LOOP   = 2'b10
   } dlb_src_t;
endpackage

// >>> src/dlb_fifo.sv
`timescale 1ns/10ps
module dlb_fifo #(
   parameter int W = 1,
   parameter int D = 4
) (
   input  wire logic         clk_i,
   input  wire logic         rst_i,
   input  wire logic         in_valid_i,
   input  wire logic [W-1:0] in_data_i,
   output logic              in_ready_o,
   output logic              out_valid_o,
   output logic [W-1:0]      out_data_o,
   input  wire logic         out_ready_i
);
   localparam int AW = (D > 1) ? $clog2(D) : 1;
   logic [W-1:0]  mem_r [D];
   logic [AW-1:0] wp_r;
   logic [AW-1:0] rp_r;
   logic [AW:0]   cnt_r;
   logic          push;
   logic          pop;

   assign in_ready_o  = (cnt_r != (AW+1)'(D));
   assign out_valid_o = (cnt_r != '0);
   assign push        = in_valid_i && in_ready_o;
   assign pop         = out_valid_o && out_ready_i;
   assign out_data_o  = mem_r[rp_r];

   always_ff @(posedge clk_i) begin
      if (push) begin
         mem_r[wp_r] <= in_data_i;
      end
   end

   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         wp_r  <= '0;
         rp_r  <= '0;
         cnt_r <= '0;
      end else begin
         if (push) begin
            wp_r <= (wp_r == AW'(D-1)) ? '0 : wp_r + 1'b1;
         end
         if (pop) begin
            rp_r <= (rp_r == AW'(D-1)) ? '0 : rp_r + 1'b1;
         end
         cnt_r <= cnt_r + (AW+1)'(push) - (AW+1)'(pop);
      end
   end
endmodule

// >>> bench/dlb_peer_model.sv
`timescale 1ns/10ps
module dlb_peer_model (
   input  wire logic       clk_i,
   input  wire logic       rst_i,
   input  wire logic       loop_en_i,
   input  wire logic       send_en_i,
   input  wire logic [1:0] stall_i,
   input  wire logic       tx_valid_i,
   input  wire logic       tx_bit_i,
   output logic            tx_ready_o,
   output logic            rx_valid_o,
   output logic            rx_bit_o
);
   logic [1:0] gap_r;

   // Stall modes: 0 ready, 1 random, 2 hold off
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         tx_ready_o <= 1'b1;
         rx_valid_o <= 1'b0;
         rx_bit_o   <= 1'b0;
         gap_r      <= 2'h0;
      end else begin
         tx_ready_o <= (stall_i == 2'h0) ? 1'b1 :
                       (stall_i == 2'h1) ? 1'($urandom) : 1'b0;
         gap_r      <= gap_r + 2'h1;
         if (loop_en_i && tx_valid_i && tx_ready_o) begin
            rx_valid_o <= 1'b1;
            rx_bit_o   <= tx_bit_i;
         end else if (send_en_i && gap_r == 2'h0) begin
            rx_valid_o <= 1'b1;
            rx_bit_o   <= 1'($urandom);
         end else begin
            // Idle line flips so stale data never looks held
            rx_valid_o <= 1'b0;
            rx_bit_o   <= ~rx_bit_o;
         end
      end
   end
endmodule

// >>> bench/dlb_ctrl_tb_top.sv
`timescale 1ns/10ps
module dlb_ctrl_tb_top;
   logic       clk, rst, rx_pkt, rx_fr, crc, tsw, psw, loop_req;
   logic       fr_v, fr_b, fr_rdy, ltx_v, ltx_b, ltx_rdy, lrx_v, lrx_b;
   logic       frx_v, frx_b, link, restart, dig_loop, err_ind, test_ind;
   logic       loop_en, send_en, err_prev;
   logic [1:0] stall, chk_mode, lrx_d;
   logic [8:0] prbs;
   logic       q[$];
   int         miscompares, checks_done, restarts, err_tog, err_cnt;
   int         n, k, e;

   dlb_ctrl #(.TICK_CYC(4), .TICKS_PER_S(1), .FLASH_TCK(2),
      .BLINK_TCK(2), .INJECT_GAP(16)) dut_u (
      .CLK_I(clk), .SYS_RST_I(rst), .RX_PKT_I(rx_pkt),
      .RX_PKT_FRAMED_I(rx_fr), .CRC_ERR_I(crc), .TEST_SW_I(tsw),
      .PAT_ERR_SW_I(psw), .REMOTE_LOOP_REQ_I(loop_req),
      .FR_TX_VALID_I(fr_v), .FR_TX_BIT_I(fr_b), .FR_TX_READY_O(fr_rdy),
      .LINE_TX_VALID_O(ltx_v), .LINE_TX_BIT_O(ltx_b),
      .LINE_TX_READY_I(ltx_rdy), .LINE_RX_VALID_I(lrx_v),
      .LINE_RX_BIT_I(lrx_b), .FR_RX_VALID_O(frx_v), .FR_RX_BIT_O(frx_b),
      .LINK_IND_O(link), .RESTART_O(restart),
      .REMOTE_DIGITAL_LOOP_O(dig_loop), .ERROR_INDICATOR_O(err_ind),
      .TEST_MODE_INDICATOR_O(test_ind));

   dlb_peer_model peer_u (.clk_i(clk), .rst_i(rst), .loop_en_i(loop_en),
      .send_en_i(send_en), .stall_i(stall), .tx_valid_i(ltx_v),
      .tx_bit_i(ltx_b), .tx_ready_o(ltx_rdy), .rx_valid_o(lrx_v),
      .rx_bit_o(lrx_b));

   initial begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end

   task automatic chk_bit(input string nm, input logic ex, input logic got);
      checks_done++;
      if (got !== ex) begin
         miscompares++;
         $display("ERROR %s expected %b seen %b", nm, ex, got);
      end
   endtask

   task automatic chk_rng(input string nm, input int lo, input int hi,
                          input int got);
      checks_done++;
      if (got < lo || got > hi) begin
         miscompares++;
         $display("ERROR %s expected %0d..%0d seen %0d", nm, lo, hi, got);
      end
   endtask

   task automatic wrap_up();
      $display("checks %0d mismatches %0d", checks_done, miscompares);
      if (miscompares == 0 && checks_done > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask

   // Bounded wait on restart (0), digital loop command (1) or error lamp (2)
   task automatic wait_on(input int sel, input logic v, input int lim,
                          output int cnt);
      logic s;
      for (cnt = 0; cnt < lim; cnt++) begin
         @(posedge clk);
         s = (sel == 0) ? restart : (sel == 1) ? dig_loop : err_ind;
         if (s === v) return;
      end
      miscompares++;
      $display("ERROR wait %0d expected %b seen timeout", sel, v);
      wrap_up();
   endtask

   task automatic pkt(input logic framed);
      @(posedge clk);
      rx_pkt <= 1'b1;
      rx_fr  <= framed;
      @(posedge clk);
      rx_pkt <= 1'b0;
   endtask

   task automatic send_fr(input int cnt);
      int got;
      got = 0;
      fr_v <= 1'b1;
      fr_b <= 1'($urandom);
      while (got < cnt) begin
         @(posedge clk);
         if (fr_rdy === 1'b1) begin
            got++;
            fr_b <= 1'($urandom);
         end
      end
      fr_v <= 1'b0;
   endtask

   task automatic restart_chk(input int thr);
      wait_on(0, 1'b1, thr * 4 + 20, n);
      chk_rng("restart cycles", (thr - 1) * 4 - 3, thr * 4 + 3, n);
      @(posedge clk);
      chk_bit("restart pulse", 1'b0, restart);
      chk_bit("link after restart", 1'b0, link);
   endtask

   // This process queues accepted framer and looped bits, then in check mode 0 matches line bits to them
   always @(posedge clk) begin
      lrx_d <= {lrx_v, lrx_b};
      err_prev <= err_ind;
      if (err_ind !== err_prev) err_tog++;
      if (dig_loop && err_ind) err_cnt++;
      if (restart) restarts++;
      if (lrx_d[1]) chk_bit("rx copy", lrx_d[0], frx_b);
      if (!rst) chk_bit("rx valid copy", lrx_d[1], frx_v);
      if (fr_v && fr_rdy) q.push_back(fr_b);
      if (loop_req && lrx_v) q.push_back(lrx_b);
      if (ltx_v && ltx_rdy && chk_mode == 2'h1) begin
         chk_bit("pattern", prbs[8], ltx_b);
         prbs <= {prbs[7:0], prbs[8] ^ prbs[4]};
      end else if (ltx_v && ltx_rdy && chk_mode == 2'h0) begin
         chk_bit("line bit", q.size() ? q.pop_front() : 1'bx, ltx_b);
      end
   end

   initial begin
      {rst, rx_pkt, rx_fr, crc, tsw, psw, loop_req, fr_v, fr_b} = 9'h100;
      {loop_en, send_en, stall, chk_mode, prbs} = 15'h01ff;
      n = $urandom(32'hce0f);
      repeat (3) @(posedge clk);
      chk_bit("link rst", 1'b0, link);
      chk_bit("tm rst", 1'b0, test_ind);
      chk_bit("ready rst", 1'b1, fr_rdy);
      rst <= 1'b0;
      restart_chk(50);
      pkt(1'b1);
      @(posedge clk);
      chk_bit("link on", 1'b1, link);
      pkt(1'b0);
      @(posedge clk);
      chk_bit("link off", 1'b0, link);
      restart_chk(4);
      $display("test link_restart done");
      stall <= 2'h2;
      send_fr(4);
      @(posedge clk);
      chk_bit("fifo full", 1'b0, fr_rdy);
      stall <= 2'h1;
      send_fr(20);
      repeat (60) @(posedge clk);
      chk_rng("queue left", 0, 0, q.size());
      $display("test fifo done");
      stall <= 2'h0;
      pkt(1'b1);
      loop_req <= 1'b1;
      send_en <= 1'b1;
      pkt(1'b0);
      restart_chk(60);
      chk_bit("tm remote", 1'b1, test_ind);
      send_en <= 1'b0;
      repeat (10) @(posedge clk);
      loop_req <= 1'b0;
      $display("test remote_end done");
      pkt(1'b1);
      {chk_mode, loop_en, stall, tsw} <= 6'b011011;
      wait_on(1, 1'b1, 4, n);
      chk_bit("tm gen", 1'b1, test_ind);
      chk_bit("framer held", 1'b0, fr_rdy);
      k = restarts;
      e = err_cnt;
      pkt(1'b0);
      wait_on(1, 1'b0, 200, n);
      chk_rng("gen cycles", 168, 184, n);
      pkt(1'b1);
      chk_rng("no restart", k, k, restarts);
      chk_rng("clean errors", e, e, err_cnt);
      wait_on(2, 1'b1, 12, n);
      e = err_tog;
      repeat (40) @(posedge clk);
      chk_rng("blink toggles", e + 4, e + 6, err_tog);
      stall <= 2'h0;
      tsw <= 1'b0;
      repeat (4) @(posedge clk);
      e = err_tog;
      repeat (20) @(posedge clk);
      chk_bit("blink stop", 1'b0, err_ind);
      chk_rng("blink quiet", e, e, err_tog);
      chk_bit("tm off", 1'b0, test_ind);
      chk_bit("data restored", 1'b1, fr_rdy);
      $display("test pattern_clean done");
      chk_mode <= 2'h2;
      {psw, tsw} <= 2'b11;
      e = err_cnt;
      repeat (100) @(posedge clk);
      chk_bit("errored flash", 1'b1, err_cnt > e);
      {psw, tsw, loop_en} <= 3'b000;
      repeat (30) @(posedge clk);
      chk_mode <= 2'h0;
      $display("test pattern_errored done");
      pkt(1'b1);
      crc <= 1'b1;
      @(posedge clk);
      crc <= 1'b0;
      wait_on(2, 1'b1, 4, n);
      chk_rng("flash delay", 0, 2, n);
      wait_on(2, 1'b0, 16, n);
      pkt(1'b0);
      e = err_tog;
      crc <= 1'b1;
      @(posedge clk);
      crc <= 1'b0;
      repeat (12) @(posedge clk);
      chk_rng("no flash link down", e, e, err_tog);
      $display("test crc_flash done");
      wrap_up();
   end
endmodule
